// [mrs_repeated_start.sv]
// Repeated-start generator of an I2C master port.
// Assumes bus pin inputs already synchronous to clk, open-drain pads outside.
//
// Summary of operation
// - Start only when request is set while the port is idle.
// - Setting the request drives SCL low.
// - With SCL seen low, load the baud counter from the reload value.
// - Release SDA high for one baud period.
// - On counter expiry with SDA high, release SCL.
// - With SCL seen high, reload; both lines must stay high one period.
// - Then drive SDA low for one baud period with SCL high.
// - Afterwards clear the request itself, no reload, keep SDA low.
// - Set start-seen status as soon as a start appears on the bus.
// - Set the transfer event flag only after the final period expires.
// - Ignore a request written while another bus event runs.
// - Collision if SDA is low when SCL rises.
// - Collision if SCL falls before SDA is driven low.
// - Buffer write during the sequence sets write collision, buffer unchanged.
// - Block writes to all eight control bits until the sequence ends.
`default_nettype none
`include "mrs_consts.svh"

module mrs_repeated_start
    import mrs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Software control writes.
    input wire logic ctrl2_wr,
    input wire logic [`MRS_CTRL2_W-1:0] ctrl2_wdata,
    input wire logic buf_wr,
    input wire logic [7:0] buf_wdata,
    input wire logic [`MRS_RELOAD_W-1:0] baud_reload_value,
    input wire logic other_event_busy,
    input wire logic event_flag_clr,
    input wire logic write_collision_flag_clr,
    input wire logic stop_seen,
    // Software status.
    output logic [`MRS_CTRL2_W-1:0] port_control_two,
    output logic [7:0] shift_buffer,
    output logic transfer_event_flag,
    output logic write_collision_flag,
    output logic start_seen,
    output logic bus_collision,
    output logic busy,
    // I2C pins, open drain: the enable pulls the line low.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    mrs_state_t state_r, state_nxt;
    logic [`MRS_CTRL2_W-1:0] ctrl2_r, ctrl2_nxt;
    logic [7:0] buf_r, buf_nxt;
    logic flag_r, flag_nxt;
    logic write_collision_flag_r, write_collision_flag_nxt;
    logic start_r, start_nxt;
    logic bcol_r, bcol_nxt;
    logic scl_low_r, scl_low_nxt;
    logic sda_low_r, sda_low_nxt;
    logic scl_d_r, sda_d_r;
    logic brg_load, brg_run, brg_exp;
    logic active;
    logic scl_rise, scl_fall, start_cond, collide;

    assign active = (state_r != MRS_IDLE);
    assign scl_rise = scl_in & ~scl_d_r;
    assign scl_fall = ~scl_in & scl_d_r;
    assign start_cond = scl_in & scl_d_r & sda_d_r & ~sda_in;

    mrs_baud_gen u_brg (
        .clk(clk),
        .reset(reset),
        .load(brg_load),
        .run(brg_run),
        .reload(baud_reload_value),
        .expired(brg_exp)
    );

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    // Collision checks apply only between SCL release and SDA assertion.
    always_comb begin
        collide = 1'b0;
        if ((state_r == MRS_SCL_RISE) && scl_rise && !sda_in) begin
            collide = 1'b1;
        end
        if ((state_r == MRS_BOTH_HIGH) && (scl_fall || !sda_in)) begin
            collide = 1'b1;
        end
    end

    always_comb begin
        state_nxt = state_r;
        ctrl2_nxt = ctrl2_r;
        scl_low_nxt = scl_low_r;
        sda_low_nxt = sda_low_r;
        brg_load = 1'b0;
        brg_run = 1'b0;
        flag_nxt = flag_r & ~event_flag_clr;
        bcol_nxt = bcol_r;
        if (ctrl2_wr && !active) begin
            ctrl2_nxt = ctrl2_wdata;
        end
        case (state_r)
            MRS_IDLE: begin
                if (ctrl2_wr && ctrl2_wdata[`MRS_CTRL2_RSTART_BIT]) begin
                    if (other_event_busy) begin
                        ctrl2_nxt[`MRS_CTRL2_RSTART_BIT] = 1'b0;
                    end else begin
                        scl_low_nxt = 1'b1;
                        bcol_nxt = 1'b0;
                        state_nxt = MRS_SCL_LOW;
                    end
                end
            end
            MRS_SCL_LOW: begin
                if (!scl_in) begin
                    brg_load = 1'b1;
                    sda_low_nxt = 1'b0;
                    state_nxt = MRS_SDA_HIGH;
                end
            end
            MRS_SDA_HIGH: begin
                brg_run = 1'b1;
                if (brg_exp && sda_in) begin
                    scl_low_nxt = 1'b0;
                    state_nxt = MRS_SCL_RISE;
                end
            end
            MRS_SCL_RISE: begin
                if (scl_in) begin
                    brg_load = 1'b1;
                    state_nxt = MRS_BOTH_HIGH;
                end
            end
            MRS_BOTH_HIGH: begin
                brg_run = 1'b1;
                if (brg_exp) begin
                    sda_low_nxt = 1'b1;
                    state_nxt = MRS_SDA_LOW;
                end
            end
            MRS_SDA_LOW: begin
                brg_run = 1'b1;
                if (brg_exp) begin
                    ctrl2_nxt[`MRS_CTRL2_RSTART_BIT] = 1'b0;
                    flag_nxt = 1'b1;
                    state_nxt = MRS_IDLE;
                end
            end
            default: begin
                state_nxt = MRS_IDLE;
            end
        endcase
        if (collide) begin
            bcol_nxt = 1'b1;
            scl_low_nxt = 1'b0;
            sda_low_nxt = 1'b0;
            ctrl2_nxt[`MRS_CTRL2_RSTART_BIT] = 1'b0;
            state_nxt = MRS_IDLE;
        end
    end

    // ------------------------------------------------------------------------
    // Buffer and status flags
    // ------------------------------------------------------------------------
    // Set beats clear for every sticky flag.
    always_comb begin
        buf_nxt = buf_r;
        write_collision_flag_nxt = write_collision_flag_r & ~write_collision_flag_clr;
        start_nxt = start_r;
        if (buf_wr) begin
            if (active) begin
                write_collision_flag_nxt = 1'b1;
            end else begin
                buf_nxt = buf_wdata;
            end
        end
        if (stop_seen) begin
            start_nxt = 1'b0;
        end
        if (start_cond) begin
            start_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= MRS_IDLE;
            ctrl2_r <= `MRS_CTRL2_RESET;
            buf_r <= `MRS_BUF_RESET;
            flag_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            start_r <= 1'b0;
            bcol_r <= 1'b0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            ctrl2_r <= ctrl2_nxt;
            buf_r <= buf_nxt;
            flag_r <= flag_nxt;
            write_collision_flag_r <= write_collision_flag_nxt;
            start_r <= start_nxt;
            bcol_r <= bcol_nxt;
            scl_low_r <= scl_low_nxt;
            sda_low_r <= sda_low_nxt;
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
        end
    end

    // Outputs: from flip-flops, with scl_out and sda_out tied low; open drain only ever pulls low.
    logic busy_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt != MRS_IDLE);
        end
    end
    assign busy = busy_r;
    assign port_control_two = ctrl2_r;
    assign shift_buffer = buf_r;
    assign transfer_event_flag = flag_r;
    assign write_collision_flag = write_collision_flag_r;
    assign start_seen = start_r;
    assign bus_collision = bcol_r;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_low_r;
    assign sda_oe = sda_low_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_scl_pulled: assert property (@(posedge clk) disable iff (reset)
        (state_r == MRS_IDLE && state_nxt == MRS_SCL_LOW) |=> scl_oe)
        else $error("SCL not pulled low after request");
    chk_flag_late: assert property (@(posedge clk) disable iff (reset)
        $rose(flag_r) |-> $past(state_r) == MRS_SDA_LOW)
        else $error("Event flag set before final period");
    chk_sda_held: assert property (@(posedge clk) disable iff (reset)
        (state_r == MRS_SDA_LOW && brg_exp && !collide) |=> sda_oe && !ctrl2_r[1])
        else $error("SDA not held low or request not cleared");
    chk_buf_kept: assert property (@(posedge clk) disable iff (reset)
        (buf_wr && active) |=> write_collision_flag_r && $stable(buf_r))
        else $error("Buffer changed during sequence");
    chk_ctrl_lock: assert property (@(posedge clk) disable iff (reset)
        (ctrl2_wr && active && !collide && state_r != MRS_SDA_LOW) |=> $stable(ctrl2_r))
        else $error("Control written while locked");
    chk_coll_abort: assert property (@(posedge clk) disable iff (reset)
        collide |=> bus_collision && !scl_oe && !sda_oe && state_r == MRS_IDLE)
        else $error("Collision did not abandon sequence");
    chk_busy_ignore: assert property (@(posedge clk) disable iff (reset)
        (state_r == MRS_IDLE && other_event_busy) |=> state_r == MRS_IDLE)
        else $error("Request taken while busy");
    chk_start_seen: assert property (@(posedge clk) disable iff (reset)
        start_cond |=> start_r)
        else $error("Start not reported");
    // Line states per phase: a wrong enable here is a glitch that other masters see.
    chk_sda_free: assert property (@(posedge clk) disable iff (reset)
        (state_r == MRS_SDA_HIGH) |-> !sda_oe && scl_oe)
        else $error("SDA not released with SCL low");
    chk_scl_free: assert property (@(posedge clk) disable iff (reset)
        (state_r == MRS_SDA_HIGH && brg_exp && sda_in) |=> !scl_oe)
        else $error("SCL not released after first period");
    chk_start_form: assert property (@(posedge clk) disable iff (reset)
        (state_r == MRS_SDA_LOW) |-> sda_oe && !scl_oe)
        else $error("Start not formed with SCL high");
    cov_done: cover property (@(posedge clk) disable iff (reset) $rose(flag_r));
    cov_coll: cover property (@(posedge clk) disable iff (reset) $rose(bcol_r));
    cov_write_collision_flag: cover property (@(posedge clk) disable iff (reset) $rose(write_collision_flag_r));
    cov_stretch: cover property (@(posedge clk) disable iff (reset)
        state_r == MRS_SCL_RISE && !scl_in);
    cov_refused: cover property (@(posedge clk) disable iff (reset)
        state_r == MRS_IDLE && ctrl2_wr && other_event_busy);
endmodule // mrs_repeated_start

`default_nettype wire

// [mrs_consts.svh]
// Constants for the repeated-start generator: control field positions and timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Control field layout
// ----------------------------------------------------------------------------
`define MRS_RELOAD_W 7
`define MRS_CTRL2_W 8
`define MRS_CTRL2_LOCK_W 5
`define MRS_CTRL2_RSTART_BIT 1
`define MRS_CTRL2_RESET 8'h00
`define MRS_BUF_RESET 8'h00

`endif

// [mrs_pkg.sv]
// Types shared by the repeated-start generator.
// Assumes mrs_consts.svh is reachable on the include path.
`default_nettype none
`include "mrs_consts.svh"

package mrs_pkg;
    // Sequence states of the repeated start.
    typedef enum logic [2:0] {
        MRS_IDLE,
        MRS_SCL_LOW,
        MRS_SDA_HIGH,
        MRS_SCL_RISE,
        MRS_BOTH_HIGH,
        MRS_SDA_LOW
    } mrs_state_t;
endpackage : mrs_pkg

`default_nettype wire

// [mrs_baud_gen.sv]
// Baud rate generator: a down counter reloaded from a 7-bit value.
// Assumes a single clock and an asynchronous active-high reset.
`default_nettype none
`include "mrs_consts.svh"

module mrs_baud_gen
    import mrs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Control.
    input wire logic load,
    input wire logic run,
    input wire logic [`MRS_RELOAD_W-1:0] reload,
    // Status.
    output logic expired
);
    logic [`MRS_RELOAD_W-1:0] cnt_r;
    logic [`MRS_RELOAD_W-1:0] cnt_nxt;
    logic expired_r;
    logic expired_nxt;

    // Count down while running; expiry is registered, high in the cycle after the count is zero.
    always_comb begin
        cnt_nxt = cnt_r;
        expired_nxt = 1'b0;
        if (load) begin
            cnt_nxt = reload;
        end else if (run) begin
            if (cnt_r == {`MRS_RELOAD_W{1'b0}}) begin
                expired_nxt = 1'b1;
                cnt_nxt = reload;
            end else begin
                cnt_nxt = cnt_r - 7'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 7'h00;
            expired_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            expired_r <= expired_nxt;
        end
    end

    assign expired = expired_r;
endmodule // mrs_baud_gen

`default_nettype wire

// [mrs_bus_partner.sv]
// Far side of the I2C lines: pull-ups, a slow slave and a rival master.
// Assumes open-drain enables from the device and bench controls set after clk rises.
`default_nettype none
module mrs_bus_partner (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Device pin enables.
    input wire logic scl_oe,
    input wire logic sda_oe,
    // Far-side behaviour.
    input wire logic [7:0] stretch,
    input wire logic sda_grab,
    input wire logic scl_grab,
    // Resolved lines.
    output logic scl_in,
    output logic sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hold_r;
    logic [1:0] hi_r;
    logic grab_r;
    // Wired-and with pull-ups, so a line reads high only when no side pulls it low.
    assign scl_in = !(scl_oe || (hold_r != 8'h00) || grab_r);
    assign sda_in = !(sda_oe || (sda_grab && scl_in));
    // Stretch keeps SCL low after release; the grab pulls SCL three cycles into a high.
    // early clock fall.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_r <= 8'h00;
            hi_r <= 2'h0;
            grab_r <= 1'b0;
        end else begin
            hold_r <= scl_oe ? stretch : hold_r - 8'((hold_r != 8'h00));
            hi_r <= !scl_in ? 2'h0 : hi_r + 2'((hi_r != 2'h3));
            grab_r <= scl_grab && (grab_r || (hi_r == 2'h2));
        end
    end
endmodule // mrs_bus_partner
`default_nettype wire

// [tb_mrs_repeated_start.sv]
// Self-checking bench for the repeated-start generator with a bus partner.
// Assumes design and partner compiled first; one 100 MHz clock.
`default_nettype none
`include "mrs_consts.svh"
module tb_mrs_repeated_start import mrs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ctrl2_wr = 1'b0, buf_wr = 1'b0, other_event_busy = 1'b0;
    logic event_flag_clr = 1'b0, write_collision_flag_clr = 1'b0, stop_seen = 1'b0;
    logic sda_grab = 1'b0, scl_grab = 1'b0;
    logic [7:0] ctrl2_wdata = 8'h00, buf_wdata = 8'h00, stretch = 8'h00;
    logic [`MRS_RELOAD_W-1:0] baud_reload_value = 7'h00;
    logic [7:0] port_control_two, shift_buffer;
    logic transfer_event_flag, write_collision_flag, start_seen, bus_collision, busy;
    logic scl_in, sda_in, scl_oe, sda_oe, scl_out, sda_out;
    int n_fail = 0, checked = 0, exp_buf = 0, cyc;
    bit [31:0] seed = 32'h94baabf1;
    int rl_q[$] = '{0, 127};

    mrs_repeated_start DUT (.clk(clk), .reset(reset), .ctrl2_wr(ctrl2_wr),
        .ctrl2_wdata(ctrl2_wdata), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
        .baud_reload_value(baud_reload_value), .other_event_busy(other_event_busy),
        .event_flag_clr(event_flag_clr), .write_collision_flag_clr(write_collision_flag_clr), .stop_seen(stop_seen),
        .port_control_two(port_control_two), .shift_buffer(shift_buffer),
        .transfer_event_flag(transfer_event_flag),
        .write_collision_flag(write_collision_flag), .start_seen(start_seen),
        .bus_collision(bus_collision), .busy(busy), .scl_in(scl_in), .sda_in(sda_in),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
    mrs_bus_partner peer (.clk(clk), .reset(reset), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .stretch(stretch), .sda_grab(sda_grab), .scl_grab(scl_grab),
        .scl_in(scl_in), .sda_in(sda_in));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Inputs always move 1 ns after the edge so no race with sampling.
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk_bit(input logic act, input logic exp, input string what);
        checked++;
        if (act !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    task automatic chk_byte(input logic [7:0] act, input logic [7:0] exp, input string what);
        checked++;
        if (act !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Mode 0 is a clean run, 1 a rival on SDA, 2 a rival pulling SCL early.
    task automatic run_rs(input int rl, input int st, input int mode);
        logic [7:0] d;
        d = 8'(rnd());
        baud_reload_value = 7'(rl);
        stretch = 8'(st);
        ctrl2_wdata = 8'h02;
        ctrl2_wr = 1'b1;
        tick();
        ctrl2_wr = 1'b0;
        chk_bit(scl_oe & busy, 1'b1, "request not taken");
        chk_byte(port_control_two, 8'h02, "request bit");
        sda_grab = (mode == 1);
        scl_grab = (mode == 2);
        cyc = 1;
        while (transfer_event_flag !== 1'b1 && bus_collision !== 1'b1 && cyc < 3000) begin
            if (cyc == 3 || cyc == 4) begin
                // One refused buffer and control write in the middle of the sequence.
                buf_wr = (cyc == 3);
                ctrl2_wr = (cyc == 3);
                buf_wdata = d;
                ctrl2_wdata = 8'h1d;
            end
            // SDA is still held from the last start in the first cycle of a new one.
            if (cyc > 1 && sda_oe === 1'b1 && busy === 1'b1) chk_bit(scl_oe, 1'b0, "scl low");
            tick();
            cyc++;
        end
        buf_wr = 1'b0;
        ctrl2_wr = 1'b0;
        chk_bit(write_collision_flag, 1'b1, "no write_collision_flag");
        chk_byte(shift_buffer, 8'(exp_buf), "buffer changed");
        chk_byte(port_control_two, 8'h00, "control after run");
        chk_bit(busy | scl_oe, 1'b0, "still active");
        if (mode == 0) begin
            chk_bit(transfer_event_flag, 1'b1, "no event flag");
            chk_bit(cyc >= 3 * (rl + 1) + st, 1'b1, "flag too early");
            chk_bit(sda_oe & ~sda_out, 1'b1, "sda not held");
            chk_bit(start_seen, 1'b1, "start not seen");
            chk_bit(bus_collision, 1'b0, "false collision");
            exp_buf = d;
            tick();
            buf_wr = 1'b1;
            tick();
            buf_wr = 1'b0;
            chk_byte(shift_buffer, 8'(exp_buf), "address not loaded");
        end else begin
            chk_bit(bus_collision, 1'b1, "no collision");
            chk_bit(sda_oe | transfer_event_flag, 1'b0, "not abandoned");
        end
        sda_grab = 1'b0;
        scl_grab = 1'b0;
        {event_flag_clr, write_collision_flag_clr, stop_seen} = 3'h7;
        tick();
        {event_flag_clr, write_collision_flag_clr, stop_seen} = 3'h0;
        tick();
        chk_bit(transfer_event_flag | write_collision_flag | start_seen, 1'b0, "clear");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        chk_byte({busy, scl_oe, sda_oe, bus_collision, start_seen, scl_out, sda_out, 1'b0},
            8'h00, "reset");
        chk_byte(port_control_two | shift_buffer, 8'h00, "reset regs");
        repeat (3) rl_q.push_back(int'(rnd() & 32'h7f));
        foreach (rl_q[i]) run_rs(rl_q[i], (i > 1) ? int'(rnd() & 32'h7) : 0, 0);
        other_event_busy = 1'b1;
        ctrl2_wdata = 8'h02;
        ctrl2_wr = 1'b1;
        tick();
        ctrl2_wr = 1'b0;
        tick();
        chk_bit(busy | scl_oe, 1'b0, "busy request taken");
        chk_byte(port_control_two, 8'h00, "request bit kept");
        other_event_busy = 1'b0;
        run_rs(5, 0, 1);
        run_rs(5, 0, 2);
        run_rs(4, 3, 0);
        print_verdict();
    end

    // Watchdog well beyond the longest expected run.
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
endmodule // tb_mrs_repeated_start
`default_nettype wire
